// [design/hvcfg_regs.vh]
// Purpose: constants for the high-voltage indirect configuration block
// Assumes: 25 MHz clock
// Notes:   command codes, field positions, reset values, latency counts
`ifndef HVCFG_REGS_VH
`define HVCFG_REGS_VH
`define HVCFG_CMD_RD_A      8'h00
`define HVCFG_CMD_RD_B      8'h01
`define HVCFG_CMD_RD_STA    8'h02
`define HVCFG_CMD_RD_MON    8'h03
`define HVCFG_CMD_WR_A      8'h08
`define HVCFG_CMD_WR_B      8'h09
`define HVCFG_SETUP_RST     8'h00
`define HVCFG_DATA_RST      12'h000
`define HVCFG_A_THERM_DIS   7
`define HVCFG_A_OSC_EN      6
`define HVCFG_A_RSVD        5
`define HVCFG_A_WAKE_DRV    4
`define HVCFG_A_SUPMON_EN   3
`define HVCFG_A_LVF_EN      2
`define HVCFG_A_LIN_HI      1
`define HVCFG_A_LIN_LO      0
`define HVCFG_B_ATTEN_EN    7
`define HVCFG_B_TMON_EN     6
`define HVCFG_B_VSHORT_EN   5
`define HVCFG_LIN_OFF       2'h0
`define HVCFG_LIN_ON        2'h2
`define HVCFG_STAT_BUSY     0
`define HVCFG_STAT_RD_OK    1
`define HVCFG_STAT_WR_OK    2
`define HVCFG_CLK_MHZ       25
`define HVCFG_LATENCY_US    10
`define HVCFG_LATENCY_CYC   (`HVCFG_LATENCY_US * `HVCFG_CLK_MHZ)
`define HVCFG_MON_LVF       3
`endif

// [design/hvcfg_store.v]
// Purpose: two 8-bit setup registers with registered read port
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes:   write and read selected by one address bit
`timescale 1ns/1ps
`include "hvcfg_regs.vh"
module hvcfg_store (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       wr_en,
  input  wire       sel_b,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  output reg  [7:0] setup_a_reg,
  output reg  [7:0] setup_b_reg
);
  always @(posedge clock) begin
    if (!rst_n) begin
      setup_a_reg <= `HVCFG_SETUP_RST;
      setup_b_reg <= `HVCFG_SETUP_RST;
      rd_data     <= `HVCFG_SETUP_RST;
    end else if (clk_en) begin
      if (wr_en && !sel_b)
        setup_a_reg <= wr_data;
      if (wr_en && sel_b)
        setup_b_reg <= wr_data;
      rd_data <= sel_b ? setup_b_reg : setup_a_reg;
    end
  end
endmodule

// [design/hvcfg_top.v]
// Purpose: indirect command/data access to two high-voltage setup registers
// Assumes: one clock, synchronous active-low reset, synchronous inputs
// Notes:   status and monitor reads return their input ports
`timescale 1ns/1ps
`include "hvcfg_regs.vh"
module hvcfg_top #(
  parameter LATENCY_CYC = `HVCFG_LATENCY_CYC
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        cmd_wr,
  input  wire [7:0]  cmd_wdata,
  output wire [7:0]  hv_command_byte,
  input  wire        data_wr,
  input  wire [11:0] data_wdata,
  output wire [11:0] hv_indirect_data,
  input  wire [7:0]  hv_status_in,
  input  wire [7:0]  hv_monitor_state,
  input  wire        thermal_event,
  input  wire        supply_low,
  input  wire        hv_interrupt_source,
  output wire        wake_pin_drive,
  output wire        wake_pin_pulldown,
  output wire        osc_power_en,
  output wire        supply_monitor_en,
  output wire        supply_irq,
  output wire        low_voltage_flag_en,
  output wire        lin_driver_en,
  output wire        atten_en,
  output wire        temp_monitor_en,
  output wire        vchan_short_en
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  localparam [15:0] LOAD_CYC = LATENCY_CYC[15:0];

  // sequencer state and status
  reg        state_reg;
  reg        state_next;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg [7:0]  cmd_reg;
  reg [7:0]  cmd_next;
  reg [11:0] data_reg;
  reg [11:0] data_next;
  reg        rd_ok_reg;
  reg        rd_ok_next;
  reg        wr_ok_reg;
  reg        wr_ok_next;
  reg        done_reg;
  reg        done_next;

  // setup values and command decode
  wire [7:0] setup_a;
  wire [7:0] setup_b;
  wire [7:0] store_rd;
  wire       cmd_rd_a;
  wire       cmd_rd_b;
  wire       cmd_rd_sta;
  wire       cmd_rd_mon;
  wire       cmd_wr_a;
  wire       cmd_wr_b;
  wire       is_rd_cfg;
  wire       is_wr_cfg;
  wire       is_rd_any;
  wire       busy;
  wire       take_cmd;
  wire       take_data;
  wire       fire;
  wire       store_wr;
  wire       thermal_cut;
  wire [1:0] lin_mode;

  assign cmd_rd_a   = (cmd_reg == `HVCFG_CMD_RD_A);
  assign cmd_rd_b   = (cmd_reg == `HVCFG_CMD_RD_B);
  assign cmd_rd_sta = (cmd_reg == `HVCFG_CMD_RD_STA);
  assign cmd_rd_mon = (cmd_reg == `HVCFG_CMD_RD_MON);
  assign cmd_wr_a   = (cmd_reg == `HVCFG_CMD_WR_A);
  assign cmd_wr_b   = (cmd_reg == `HVCFG_CMD_WR_B);
  assign is_rd_cfg  = cmd_rd_a || cmd_rd_b;
  assign is_wr_cfg  = cmd_wr_a || cmd_wr_b;
  assign is_rd_any  = is_rd_cfg || cmd_rd_sta || cmd_rd_mon;

  // busy covers the countdown and the extra read-back cycle
  assign busy      = (state_reg == ST_BUSY) || done_reg;
  // requests made while busy are dropped
  assign take_cmd  = cmd_wr && !busy;
  assign take_data = data_wr && !busy;
  assign fire      = (state_reg == ST_BUSY) && (count_reg == 16'h0001);
  assign store_wr  = fire && is_wr_cfg;

  // setup storage with registered read-back
  hvcfg_store hvcfg_store_inst (
    .clock       (clock),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .wr_en       (store_wr),
    .sel_b       (cmd_reg[0]),
    .wr_data     (data_reg[7:0]),
    .rd_data     (store_rd),
    .setup_a_reg (setup_a),
    .setup_b_reg (setup_b)
  );

  always @* begin
    // hold everything but done, which clears each cycle, unless the sequencer moves it
    state_next = state_reg;
    count_next = count_reg;
    cmd_next   = cmd_reg;
    data_next  = data_reg;
    rd_ok_next = rd_ok_reg;
    wr_ok_next = wr_ok_reg;
    done_next  = 1'b0;

    case (state_reg)
      ST_IDLE: begin
        if (take_data) begin
          data_next = {4'h0, data_wdata[7:0]};
        end
        if (take_cmd) begin
          cmd_next   = cmd_wdata;
          count_next = LOAD_CYC;
          state_next = ST_BUSY;
        end
      end

      ST_BUSY: begin
        count_next = count_reg - 16'h0001;
        // the last count applies the command
        if (fire) begin
          state_next = ST_IDLE;
          done_next  = is_rd_cfg;
          rd_ok_next = is_rd_any;
          wr_ok_next = is_wr_cfg;
          if (cmd_rd_sta) begin
            data_next = {cmd_reg[3:0], hv_status_in};
          end
          if (cmd_rd_mon) begin
            data_next = {cmd_reg[3:0], hv_monitor_state};
          end
          if (is_wr_cfg) begin
            data_next = {cmd_reg[3:0], data_reg[7:0]};
          end
        end
      end

      default: begin
        state_next = ST_IDLE;
        count_next = 16'h0000;
      end
    endcase

    // setup read-back lands one cycle after the store's registered read
    if (done_reg) begin
      data_next = {cmd_reg[3:0], store_rd};
    end
  end

  // clock enable low freezes every register
  always @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      cmd_reg   <= 8'h00;
      data_reg  <= `HVCFG_DATA_RST;
      rd_ok_reg <= 1'b0;
      wr_ok_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      count_reg <= count_next;
      cmd_reg   <= cmd_next;
      data_reg  <= data_next;
      rd_ok_reg <= rd_ok_next;
      wr_ok_reg <= wr_ok_next;
      done_reg  <= done_next;
    end
  end

  // command status view: bits 7-3 read as zero
  assign hv_command_byte  = {5'h00, wr_ok_reg, rd_ok_reg, busy};
  assign hv_indirect_data = data_reg;

  // wake driver cut while a thermal event stands and shutdown is armed
  assign thermal_cut       = thermal_event && !setup_a[`HVCFG_A_THERM_DIS];
  assign wake_pin_drive    = setup_a[`HVCFG_A_WAKE_DRV] && !thermal_cut;
  assign wake_pin_pulldown = !setup_a[`HVCFG_A_WAKE_DRV];

  // setup a: oscillator, supply monitor and low-voltage flag
  assign osc_power_en        = setup_a[`HVCFG_A_OSC_EN];
  assign supply_monitor_en   = setup_a[`HVCFG_A_SUPMON_EN];
  assign supply_irq          = setup_a[`HVCFG_A_SUPMON_EN] && supply_low
                               && hv_interrupt_source;
  assign low_voltage_flag_en = setup_a[`HVCFG_A_LVF_EN];

  // only code 10 enables the line driver, reserved codes leave it off
  assign lin_mode      = {setup_a[`HVCFG_A_LIN_HI], setup_a[`HVCFG_A_LIN_LO]};
  assign lin_driver_en = (lin_mode == `HVCFG_LIN_ON);

  // setup b: attenuator, temperature monitor and channel short
  assign atten_en        = setup_b[`HVCFG_B_ATTEN_EN];
  assign temp_monitor_en = setup_b[`HVCFG_B_TMON_EN];
  assign vchan_short_en  = setup_b[`HVCFG_B_VSHORT_EN];
endmodule

// [test/hvcfg_sva.sv]
// Purpose: port checks of hvcfg_top
// Assumes: LATENCY_CYC of 4
// Notes:   bound after the module
`timescale 1ns/1ps
module hvcfg_sva #(parameter LATENCY_CYC = 4) (
  input wire        clock,
  input wire        rst_n,
  input wire [7:0]  hv_command_byte,
  input wire [11:0] hv_indirect_data,
  input wire        wake_pin_drive,
  input wire        wake_pin_pulldown,
  input wire        supply_irq,
  input wire        supply_monitor_en,
  input wire        supply_low,
  input wire        hv_interrupt_source,
  input wire        lin_driver_en
);
  wire busy = hv_command_byte[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_WAKE: assert property (wake_pin_drive |-> !wake_pin_pulldown) else $error("wake");
  AST_IRQ: assert property (supply_irq ==
    (supply_monitor_en && supply_low && hv_interrupt_source)) else $error("irq");
  AST_HOLD: assert property ($rose(busy) |-> busy[*4]) else $error("busy short");
  AST_END: assert property ($rose(busy) |-> ##[4:5] !busy) else $error("busy long");
  AST_KEEP: assert property (!busy && !$past(busy) |->
    $stable({lin_driver_en, wake_pin_pulldown})) else $error("setup moved");
  AST_OK: assert property ($fell(busy) |-> !(&hv_command_byte[2:1])) else $error("ok");
  AST_NIB: assert property ($fell(busy) && hv_command_byte[2] |->
    hv_indirect_data[11:9] == 3'h4) else $error("wr nibble");
  AST_RD: assert property ($fell(busy) && hv_command_byte[1] |->
    hv_indirect_data[11:10] == 2'h0) else $error("rd nibble");
endmodule
bind hvcfg_top hvcfg_sva #(.LATENCY_CYC(LATENCY_CYC)) hvcfg_sva_inst (.*);

// [test/hvcfg_cpu.sv]
// Purpose: core side issuing data and command writes
// Assumes: changes at the falling edge
// Notes:   timed_out set when busy is still set after 20 falling edges
`timescale 1ns/1ps
module hvcfg_cpu (
  input  wire        clock,
  input  wire [7:0]  hv_command_byte,
  output reg         cmd_wr,
  output reg  [7:0]  cmd_wdata,
  output reg         data_wr,
  output reg  [11:0] data_wdata,
  output reg         timed_out
);
  initial {cmd_wr, cmd_wdata, data_wr, data_wdata, timed_out} = 23'h0;
  task idle; integer i; begin
    for (i = 0; i < 20 && hv_command_byte[0] !== 1'b0; i = i + 1) @(negedge clock);
    if (hv_command_byte[0] !== 1'b0) timed_out = 1'b1;
  end endtask
  task send(input c, input [7:0] v); begin
    idle;
    cmd_wr = c;
    data_wr = !c;
    cmd_wdata = v;
    data_wdata = {4'h0, v};
    @(negedge clock);
    {cmd_wr, data_wr} = 2'h0;
    cmd_wdata = ~v;
    data_wdata = ~data_wdata;
    @(negedge clock);
  end endtask
endmodule

// [test/hvcfg_top_tb.sv]
// Purpose: self-checking bench for hvcfg_top
// Assumes: LATENCY_CYC of 4
// Notes:   core side modelled by hvcfg_cpu
`timescale 1ns/1ps
module hvcfg_top_tb;
  reg         clock = 0, rst_n = 0, therm = 0, low = 1;
  reg  [7:0]  v;
  wire [7:0]  cb, cwd;
  wire [11:0] hd, dwd;
  wire        cw, dw, to, wd, wp, osc, pm, irq, lvf, lin, att, tm, vs;
  wire [31:0] seq_a = 32'hDC1C4282;
  integer     n_mismatch = 0, checks = 0, i;
  always #20 clock = ~clock;
  hvcfg_cpu hvcfg_cpu_inst (.clock(clock), .hv_command_byte(cb), .cmd_wr(cw), .cmd_wdata(cwd),
    .data_wr(dw), .data_wdata(dwd), .timed_out(to));
  hvcfg_top #(.LATENCY_CYC(4)) hvcfg_top_inst (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
    .cmd_wr(cw), .cmd_wdata(cwd), .hv_command_byte(cb), .data_wr(dw), .data_wdata(dwd),
    .hv_indirect_data(hd), .hv_status_in(8'h5A), .hv_monitor_state(8'hC3),
    .thermal_event(therm), .supply_low(low), .hv_interrupt_source(1'b1), .wake_pin_drive(wd),
    .wake_pin_pulldown(wp), .osc_power_en(osc), .supply_monitor_en(pm), .supply_irq(irq),
    .low_voltage_flag_en(lvf), .lin_driver_en(lin), .atten_en(att), .temp_monitor_en(tm),
    .vchan_short_en(vs));
  task chk(input [39:0] nm, input [11:0] e, input [11:0] g); begin
    checks = checks + 1;
    if (g !== e || to) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %0s exp %h got %h", nm, e, g);
    end
  end endtask
  task wr(input [7:0] a, input [7:0] d); begin
    hvcfg_cpu_inst.send(1'b0, d);
    hvcfg_cpu_inst.send(1'b1, a);
    hvcfg_cpu_inst.idle;
  end endtask
  task rd(input [7:0] a, input [7:0] e); begin
    hvcfg_cpu_inst.send(1'b1, a);
    hvcfg_cpu_inst.idle;
    chk("data", {a[3:0], e}, hd);
  end endtask
  task t_a; begin
    chk("rst", 12'h001, {cb, 3'h0, wp});
    rd(8'h00, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = seq_a[8 * (3 - i) +: 8];
      wr(8'h08, v & 8'hDF);
      rd(8'h00, v);
      chk("outs", {5'h0, v[6], v[4], !v[4], v[3], v[3], v[2], v[1:0] == 2'h2},
        {5'h0, osc, wd, wp, pm, irq, lvf, lin});
      chk("stat", 12'h002, {4'h0, cb});
    end
    $display("t_a done");
  end endtask
  task t_b; begin
    wr(8'h08, 8'h10);
    therm = 1;
    @(negedge clock);
    chk("therm", 12'h000, {11'h0, wd});
    wr(8'h08, 8'h90);
    chk("therm", 12'h001, {11'h0, wd});
    therm = 0;
    rd(8'h01, 8'h00);
    wr(8'h09, 8'hA5);
    rd(8'h01, 8'hA5);
    chk("b", 12'h005, {9'h0, att, tm, vs});
    wr(8'h09, 8'h40);
    chk("b", 12'h002, {9'h0, att, tm, vs});
    rd(8'h02, 8'h5A);
    rd(8'h00, 8'h90);
    wr(8'h08, 8'h08);
    chk("irq", 12'h003, {10'h0, pm, irq});
    low = 0;
    @(negedge clock);
    chk("irq", 12'h002, {10'h0, pm, irq});
    rd(8'h03, 8'hC3);
    hvcfg_cpu_inst.send(1'b1, 8'h05);
    hvcfg_cpu_inst.idle;
    chk("bad", 12'h000, {4'h0, cb});
    rst_n = 0;
    repeat (2) @(negedge clock);
    rst_n = 1;
    rd(8'h00, 8'h00);
    $display("t_b done");
  end endtask
  task close_out; begin
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1;
    t_a;
    if (!to) t_b;
    if (to) n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
